// ===== rtl/idpu_pointer_unit.v
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// - plain access uses pointer, pointer unchanged
// - post-increment uses pointer, then adds one
// - post-decrement uses pointer, then subtracts one
// - pre-increment adds one, uses new value
// - accumulator has no reset value
// - unimplemented bits read zero, ignore writes
`include "idpu_regs.vh"
module idpu_pointer_unit (
  input wire i_core_clk, // core clock, 20 MHz
  input wire i_rst, // synchronous reset, active high
  input wire [7:0] i_addr, // register index
  input wire [7:0] i_wdata, // write data
  input wire i_wr, // write strobe
  input wire i_rd, // read strobe
  output reg [7:0] o_rdata, // read data, cycle after read strobe
  input wire [7:0] i_mem_rdata, // data memory read data, combinational
  output reg [11:0] o_mem_addr, // data memory address
  output reg [7:0] o_mem_wdata, // data memory write data
  output reg o_mem_we, // data memory write pulse
  output reg [3:0] o_bank_sel, // bank select for direct addressing
  output reg [7:0] o_accum, // working accumulator
  output reg [4:0] o_flags // arithmetic flags
);
  // pointer storage: low byte plus four-bit high part each
  reg [7:0] ptr_low_q [0:2];
  reg [3:0] ptr_high_q [0:2];
  reg [7:0] accum_q;
  reg [3:0] bank_q;
  reg [4:0] flags_q;
  reg [7:0] accum_d;
  reg [3:0] bank_d;
  reg [4:0] flags_d;
  reg [7:0] rdata_d;
  reg [11:0] mem_addr_d;
  reg mem_we_d;
  reg virt_sel;
  reg virt_hit;
  reg [1:0] virt_ptr;
  reg [1:0] virt_mode;
  reg [11:0] cur_ptr;
  reg [11:0] next_ptr;
  reg [11:0] use_addr;
  reg [7:0] low_rd;
  reg [3:0] high_rd;

  // decode of the virtual access window; slot 3 stays unmapped because
  // the offset-by-accumulator access is not offered by this block
  always @* begin
    virt_sel = 1'b0;
    virt_ptr = i_addr[3:2];
    virt_mode = i_addr[1:0];
    if ((i_addr[7:4] == `IDPU_VIRT_PAGE) && (virt_ptr != `IDPU_VIRT_NONE)) begin
      virt_sel = 1'b1;
    end
    virt_hit = virt_sel & (i_wr | i_rd);
  end

  // current value of the pointer named by the window slot
  always @* begin
    cur_ptr = 12'h000;
    low_rd = 8'h00;
    high_rd = 4'h0;
    if (virt_ptr == 2'h0) begin
      low_rd = ptr_low_q[0];
      high_rd = ptr_high_q[0];
    end else if (virt_ptr == 2'h1) begin
      low_rd = ptr_low_q[1];
      high_rd = ptr_high_q[1];
    end else if (virt_ptr == 2'h2) begin
      low_rd = ptr_low_q[2];
      high_rd = ptr_high_q[2];
    end
    cur_ptr = {high_rd, low_rd};
    next_ptr = cur_ptr;
    use_addr = cur_ptr;
    // the sum is 12 bits wide, so carry and borrow cross the byte boundary
    case (virt_mode)
      `IDPU_MODE_PLAIN: begin
        next_ptr = cur_ptr;
      end
      `IDPU_MODE_POSTINC: begin
        next_ptr = cur_ptr + 12'h001;
      end
      `IDPU_MODE_POSTDEC: begin
        next_ptr = cur_ptr - 12'h001;
      end
      `IDPU_MODE_PREINC: begin
        next_ptr = cur_ptr + 12'h001;
        use_addr = next_ptr;
      end
      default: begin
        next_ptr = cur_ptr;
        use_addr = cur_ptr;
      end
    endcase
  end

  // limitation: o_mem_addr follows the access by one edge, so the memory
  // must answer a virtual read from its own copy of the pointed location
  // within the strobe cycle; the address then holds until the next access
  always @* begin
    mem_addr_d = o_mem_addr;
    mem_we_d = 1'b0;
    if (virt_hit) begin
      mem_addr_d = use_addr;
      mem_we_d = i_wr;
    end
  end

  // unmapped indices and bits above each field read as zero
  always @* begin
    rdata_d = 8'h00;
    if (virt_hit) begin
      rdata_d = i_mem_rdata;
    end else if (i_addr == `IDPU_OFF_PTR0_LOW) begin
      rdata_d = ptr_low_q[0];
    end else if (i_addr == `IDPU_OFF_PTR0_HIGH) begin
      rdata_d = {4'h0, ptr_high_q[0]};
    end else if (i_addr == `IDPU_OFF_ACCUM) begin
      rdata_d = accum_q;
    end else if (i_addr == `IDPU_OFF_PTR1_LOW) begin
      rdata_d = ptr_low_q[1];
    end else if (i_addr == `IDPU_OFF_PTR1_HIGH) begin
      rdata_d = {4'h0, ptr_high_q[1]};
    end else if (i_addr == `IDPU_OFF_BANK_SEL) begin
      rdata_d = {4'h0, bank_q};
    end else if (i_addr == `IDPU_OFF_PTR2_LOW) begin
      rdata_d = ptr_low_q[2];
    end else if (i_addr == `IDPU_OFF_PTR2_HIGH) begin
      rdata_d = {4'h0, ptr_high_q[2]};
    end else if (i_addr == `IDPU_OFF_FLAGS) begin
      rdata_d = {3'h0, flags_q};
    end
  end

  // the three pointers share one register shape
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ptr
      // per-pointer register indices held at bus width, slot index at two bits, so every compare is exact
      localparam [1:0] PTR_IDX = (g == 0) ? 2'h0 : ((g == 1) ? 2'h1 : 2'h2);
      localparam [7:0] LOW_IDX = (g == 0) ? `IDPU_OFF_PTR0_LOW :
        ((g == 1) ? `IDPU_OFF_PTR1_LOW : `IDPU_OFF_PTR2_LOW);
      localparam [7:0] HIGH_IDX = (g == 0) ? `IDPU_OFF_PTR0_HIGH :
        ((g == 1) ? `IDPU_OFF_PTR1_HIGH : `IDPU_OFF_PTR2_HIGH);
      reg [7:0] low_d;
      reg [3:0] high_d;
      // a direct write racing an indirect access is dropped, not merged,
      // so the pointer never ends up half updated
      always @* begin
        low_d = ptr_low_q[g];
        high_d = ptr_high_q[g];
        if (virt_hit && (virt_ptr == PTR_IDX)) begin
          high_d = next_ptr[11:8];
          low_d = next_ptr[7:0];
        end else if (i_wr && (i_addr == LOW_IDX)) begin
          low_d = i_wdata;
        end else if (i_wr && (i_addr == HIGH_IDX)) begin
          high_d = i_wdata[3:0];
        end
      end
      always @(posedge i_core_clk) begin
        if (i_rst) begin
          ptr_high_q[g] <= `IDPU_RST_HIGH;
          ptr_low_q[g] <= `IDPU_RST_PTR_LOW;
        end else begin
          ptr_high_q[g] <= high_d;
          ptr_low_q[g] <= low_d;
        end
      end
    end
  endgenerate

  // direct register writes decode one index per cycle
  always @* begin
    accum_d = accum_q;
    bank_d = bank_q;
    flags_d = flags_q;
    if (!i_wr) begin
      accum_d = accum_q;
    end else if (i_addr == `IDPU_OFF_ACCUM) begin
      accum_d = i_wdata;
    end else if (i_addr == `IDPU_OFF_BANK_SEL) begin
      bank_d = i_wdata[3:0];
    end else if (i_addr == `IDPU_OFF_FLAGS) begin
      flags_d = i_wdata[4:0];
    end
  end

  // no reset branch: the accumulator is unknown until software loads it,
  // which saves reset fan-out on a register that code always writes first
  always @(posedge i_core_clk) begin
    accum_q <= accum_d;
    o_accum <= accum_q;
  end

  // every output is a flop so the core sees clean edges
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      bank_q <= `IDPU_RST_BANK;
      flags_q <= `IDPU_RST_FLAGS;
      o_rdata <= 8'h00;
      o_mem_addr <= 12'h000;
      o_mem_wdata <= 8'h00;
      o_mem_we <= 1'b0;
      o_bank_sel <= `IDPU_RST_BANK;
      o_flags <= `IDPU_RST_FLAGS;
    end else begin
      bank_q <= bank_d;
      flags_q <= flags_d;
      // read data parks at zero outside its answer cycle
      o_rdata <= i_rd ? rdata_d : 8'h00;
      o_mem_addr <= mem_addr_d;
      o_mem_wdata <= i_wdata;
      o_mem_we <= mem_we_d;
      o_bank_sel <= bank_q;
      o_flags <= flags_q;
    end
  end
endmodule // idpu_pointer_unit

// ===== rtl/idpu_regs.vh
`ifndef IDPU_REGS_VH
`define IDPU_REGS_VH
// register indices on the plain register port (8-bit address)
`define IDPU_ADDR_W 8
`define IDPU_DATA_W 8
`define IDPU_PTR_W 12
`define IDPU_OFF_PTR0_LOW 8'h00
`define IDPU_OFF_PTR0_HIGH 8'h01
`define IDPU_OFF_ACCUM 8'h02
`define IDPU_OFF_PTR1_LOW 8'h03
`define IDPU_OFF_PTR1_HIGH 8'h04
`define IDPU_OFF_BANK_SEL 8'h05
`define IDPU_OFF_PTR2_LOW 8'h06
`define IDPU_OFF_PTR2_HIGH 8'h07
`define IDPU_OFF_FLAGS 8'h08
// virtual access addresses: base + 4*pointer + mode
`define IDPU_OFF_VIRT_BASE 8'h10
// upper nibble of the virtual window, and the window slot left unmapped
`define IDPU_VIRT_PAGE 4'h1
`define IDPU_VIRT_NONE 2'h3
`define IDPU_MODE_PLAIN 2'h0
`define IDPU_MODE_POSTINC 2'h1
`define IDPU_MODE_POSTDEC 2'h2
`define IDPU_MODE_PREINC 2'h3
// field layout
`define IDPU_HIGH_MASK 8'h0f
`define IDPU_BANK_MASK 8'h0f
`define IDPU_FLAGS_MASK 8'h1f
`define IDPU_RST_HIGH 4'h0
`define IDPU_RST_BANK 4'h0
`define IDPU_RST_PTR_LOW 8'h00
`define IDPU_RST_FLAGS 5'h00
`endif

// ===== tb/idpu_props.sv
`timescale 1ns/10ps
module idpu_props (
  input logic i_core_clk, // core clock
  input logic i_rst, // synchronous reset, active high
  input logic i_wr, // write strobe
  input logic i_rd, // read strobe
  input logic [7:0] i_addr, // register index
  input logic [7:0] i_wdata, // write data
  input logic [7:0] o_rdata, // read data
  input logic o_mem_we, // memory write pulse
  input logic [7:0] o_mem_wdata, // memory write data
  input logic [11:0] o_mem_addr, // memory address
  input logic [3:0] o_bank_sel // bank select copy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire pl = i_rd && i_addr == 8'h14;
  wire pi = i_rd && i_addr == 8'h15;
  wire pd = i_rd && i_addr == 8'h16;
  wire pr = i_rd && i_addr == 8'h17;
  wire vw = i_wr && i_addr[7:4] == 4'h1 && i_addr[3:2] != 2'h3;
  wire hr = i_rd && (i_addr == 8'h01 || i_addr == 8'h04 || i_addr == 8'h05 || i_addr == 8'h07);
  virt_write_a: assert property (vw |=> o_mem_we && o_mem_wdata == $past(i_wdata)) else $error("no mem write");
  write_cause_a: assert property (o_mem_we |-> $past(vw)) else $error("stray mem write");
  high_zero_a: assert property (hr |=> o_rdata[7:4] == 4'h0) else $error("upper bits set");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("stale read data");
  plain_hold_a: assert property (pl ##1 pl |=> $stable(o_mem_addr)) else $error("plain moved");
  post_inc_a: assert property (pi ##1 pi |=> o_mem_addr == $past(o_mem_addr) + 12'h001) else $error("inc");
  post_dec_a: assert property (pd ##1 pd |=> o_mem_addr == $past(o_mem_addr) - 12'h001) else $error("dec");
  pre_inc_a: assert property (pl ##1 pr |=> o_mem_addr == $past(o_mem_addr) + 12'h001) else $error("pre");
  bank_mask_a: assert property (i_wr && i_addr == 8'h05 |=> ##1 {4'h0, o_bank_sel} == ($past(i_wdata, 2) & 8'h0f))
    else $error("bank");
  cover property (pi ##1 pi);
  cover property (pd ##1 pd);
  cover property (pl ##1 pr);
  cover property (vw);
endmodule // idpu_props
bind idpu_pointer_unit idpu_props u_props (.*);

// ===== tb/idpu_mem_model.sv
`timescale 1ns/10ps
module idpu_mem_model (
  input logic i_core_clk, // clock
  input logic i_we, // write pulse
  input logic [11:0] i_ra, // read address, from the bench
  input logic [11:0] i_wa, // write address
  input logic [7:0] i_wd, // write data
  output logic [7:0] o_rd // read data, combinational
);
  logic [7:0] mem_q [0:4095];
  // read address comes from the bench, since the block registers its own address
  assign o_rd = mem_q[i_ra];
  always @(posedge i_core_clk) if (i_we) mem_q[i_wa] <= i_wd;
endmodule // idpu_mem_model

// ===== tb/idpu_pointer_unit_tb.sv
`timescale 1ns/10ps
module idpu_pointer_unit_tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0;
  logic [7:0] a = 0, wd = 0;
  logic [11:0] ma = 0;
  wire [7:0] rdat, mrd, mwd, acc;
  wire [11:0] mad;
  wire mwe;
  wire [3:0] bank;
  wire [4:0] flg;
  int fail_count = 0, compares = 0;
  idpu_pointer_unit dut (.i_core_clk(clk), .i_rst(rst), .i_addr(a), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdat), .i_mem_rdata(mrd), .o_mem_addr(mad), .o_mem_wdata(mwd), .o_mem_we(mwe),
    .o_bank_sel(bank), .o_accum(acc), .o_flags(flg));
  idpu_mem_model mem (.i_core_clk(clk), .i_we(mwe), .i_ra(ma), .i_wa(mad), .i_wd(mwd), .o_rd(mrd));
  initial forever #25 clk = ~clk;
  task final_report;
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [11:0] s, e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task wrt(input logic [7:0] ad, d);
    @(posedge clk); wr <= 1; a <= ad; wd <= d;
    @(posedge clk); wr <= 0;
  endtask
  task rdc(input string n, input logic [7:0] ad, e, input logic [11:0] m);
    @(posedge clk); rd <= 1; a <= ad; ma <= m;
    @(posedge clk); rd <= 0;
    @(negedge clk); chk(n, rdat, e);
  endtask
  // two reads with no gap, data unchecked
  task pair(input logic [7:0] a1, a2);
    @(posedge clk); rd <= 1; a <= a1;
    @(posedge clk); a <= a2;
    @(posedge clk); rd <= 0;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    rdc("p0hi", 8'h01, 8'h00, 0);
    wrt(8'h01, 8'hff);
    rdc("p0hi", 8'h01, 8'h0f, 0);
    wrt(8'h08, 8'hff);
    rdc("flags", 8'h08, 8'h1f, 0);
    chk("flags_out", flg, 5'h1f);
    wrt(8'h09, 8'h55);
    rdc("unmapped", 8'h09, 8'h00, 0);
    wrt(8'h05, 8'h3c);
    rdc("bank", 8'h05, 8'h0c, 0);
    chk("bank_out", bank, 4'hc);
    wrt(8'h03, 8'hff);
    wrt(8'h04, 8'h00);
    wrt(8'h15, 8'ha5);
    rdc("p1hi", 8'h04, 8'h01, 0);
    chk("wr_addr", mad, 12'h0ff);
    rdc("p1lo", 8'h03, 8'h00, 0);
    wrt(8'h16, 8'h5a);
    rdc("plain1", 8'h14, 8'ha5, 12'h0ff);
    chk("rd_addr", mad, 12'h0ff);
    rdc("p1lo", 8'h03, 8'hff, 0);
    rdc("pre1", 8'h17, 8'h5a, 12'h100);
    chk("pre_addr", mad, 12'h100);
    wrt(8'h13, 8'h42);
    rdc("plain0", 8'h10, 8'h42, 12'hf01);
    chk("p0_addr", mad, 12'hf01);
    rdc("p0lo", 8'h00, 8'h01, 0);
    wrt(8'h06, 8'h10);
    wrt(8'h1b, 8'h77);
    rdc("plain2", 8'h18, 8'h77, 12'h011);
    chk("p2_addr", mad, 12'h011);
    wrt(8'h02, 8'h99);
    rdc("accum", 8'h02, 8'h99, 0);
    chk("acc_out", acc, 8'h99);
    rdc("slot3", 8'h1c, 8'h00, 0);
    pair(8'h14, 8'h14);
    pair(8'h15, 8'h15);
    pair(8'h16, 8'h16);
    pair(8'h14, 8'h17);
    rdc("p1lo", 8'h03, 8'h01, 0);
    final_report;
  end
  initial begin
    #100000;
    fail_count++;
    final_report;
  end
endmodule // idpu_pointer_unit_tb
